// ### design/rscs_pkg.sv
// Package with register map, field positions and reset values of the block
package rscs_pkg;

   // ----------------------------------------------------------------
   // Register word addresses on the Avalon-MM slave
   // ----------------------------------------------------------------
   localparam int RSCS_ADDR_W = 2;
   localparam logic [1:0] RSCS_ADDR_CAUSE = 2'h0;
   localparam logic [1:0] RSCS_ADDR_STATUS = 2'h1;
   localparam logic [1:0] RSCS_ADDR_MASK = 2'h2;

   // ----------------------------------------------------------------
   // Field positions of reset_cause_control
   // ----------------------------------------------------------------
   localparam int RSCS_REG_W = 16;
   localparam int RSCS_BIT_POWER_ON = 0;
   localparam int RSCS_BIT_BROWN_OUT = 1;
   localparam int RSCS_BIT_IDLE = 2;
   localparam int RSCS_BIT_SLEEP = 3;
   localparam int RSCS_BIT_WATCHDOG = 4;
   localparam int RSCS_BIT_SOFT_WDT = 5;
   localparam int RSCS_BIT_INSTR = 6;
   localparam int RSCS_BIT_PIN = 7;
   localparam int RSCS_BIT_REG_STBY = 8;
   localparam int RSCS_BIT_CFG_MISM = 9;
   localparam int RSCS_BIT_ILLEGAL = 14;
   localparam int RSCS_BIT_TRAP = 15;

   // Reset value: power-on and brown-out flags set
   localparam logic [15:0] RSCS_CAUSE_RESET = 16'h0003;
   // Implemented bits; bits 13..10 read as zero
   localparam logic [15:0] RSCS_CAUSE_WMASK = 16'hc3ff;
   // Value left after a power-on event
   localparam logic [15:0] RSCS_CAUSE_POR_ONLY = 16'h0001;
   // Cause flags that also raise interrupt status
   localparam logic [15:0] RSCS_EVENT_MASK = 16'hc2d3;

   // ----------------------------------------------------------------
   // Reset source indices and the flag each one sets
   // ----------------------------------------------------------------
   localparam int RSCS_NSRC = 8;
   localparam int RSCS_SRC_POR = 0;
   localparam int RSCS_SRC_BROWN = 1;
   localparam int RSCS_SRC_PIN = 2;
   localparam int RSCS_SRC_INSTR = 3;
   localparam int RSCS_SRC_WDT = 4;
   localparam int RSCS_SRC_CFG = 5;
   localparam int RSCS_SRC_TRAP = 6;
   localparam int RSCS_SRC_ILL = 7;
   localparam int RSCS_SRC_BIT [RSCS_NSRC] = '{
      RSCS_BIT_POWER_ON, RSCS_BIT_BROWN_OUT, RSCS_BIT_PIN, RSCS_BIT_INSTR,
      RSCS_BIT_WATCHDOG, RSCS_BIT_CFG_MISM, RSCS_BIT_TRAP, RSCS_BIT_ILLEGAL};

   // Bus handshake: waitrequest idles high
   localparam logic RSCS_WAIT_IDLE = 1'b1;

endpackage : rscs_pkg

// ### design/rscs_source_merge.sv
// Merges the reset sources into one registered reset and per-source edges
module rscs_source_merge
   import rscs_pkg::*;
#(
   parameter int NSRC = RSCS_NSRC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [NSRC-1:0] src,
   output logic any_q,
   output logic [NSRC-1:0] rise_q
);

   // ----------------------------------------------------------------
   // Combined reset
   // ----------------------------------------------------------------
   // Held while any source is high; release lands on a clock edge
   always_ff @(posedge clk) begin
      if (rst) begin
         any_q <= 1'b1;
      end else if (clk_en) begin
         any_q <= |src;
      end
   end

   // ----------------------------------------------------------------
   // Per-source rising edges
   // ----------------------------------------------------------------
   logic [NSRC-1:0] prev_q;

   // A source held high for many cycles counts as one event
   for (genvar i = 0; i < NSRC; i++) begin : g_edge
      always_ff @(posedge clk) begin
         if (rst) begin
            prev_q[i] <= 1'b0;
            rise_q[i] <= 1'b0;
         end else if (clk_en) begin
            prev_q[i] <= src[i];
            rise_q[i] <= src[i] & ~prev_q[i];
         end
      end
   end

endmodule : rscs_source_merge

// ### design/rscs_top.sv
// Reset source combiner with reset cause register and Avalon-MM slave
//
// Summary of operation
// - All reset sources merge into one output.
// - Any active source asserts the master reset.
// - Illegal opcode, uninit register, security raise illegal.
// - System reset clears the software watchdog enable, keeps other bits.
// - Every reset kind sets its own cause flag.
// - Power-on clears all flags but power-on.
// - Software may set or clear any flag.
// - Software writing flags never causes a reset.
// - Register also holds watchdog enable and sleep history.
// - Bit nine flags a configuration mismatch reset.
// - Fuse enable runs watchdog regardless of software.
// - Bit two flags that idle mode was entered.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
module rscs_top
   import rscs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // Reset sources, active high levels
   input wire logic power_on_event,
   input wire logic brown_out_event,
   input wire logic master_clear_pin,
   input wire logic reset_instruction,
   input wire logic watchdog_timeout,
   input wire logic config_mismatch,
   input wire logic trap_conflict,
   input wire logic illegal_opcode,
   input wire logic uninit_wreg,
   input wire logic security_violation,
   // Power state reports and nonvolatile setting
   input wire logic idle_entered,
   input wire logic sleep_entered,
   input wire logic fuse_watchdog_enable,
   // Avalon-MM slave
   input wire logic [RSCS_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Outputs to the rest of the chip
   output logic master_system_reset,
   output logic watchdog_run,
   output logic regulator_sleep_standby,
   output logic irq
);

   // ----------------------------------------------------------------
   // Source vector and merge
   // ----------------------------------------------------------------
   logic [RSCS_NSRC-1:0] src;
   logic [RSCS_NSRC-1:0] src_rise;
   logic sys_rst_q;
   logic illegal_any;

   // Three distinct faults share one illegal-condition source
   assign illegal_any = illegal_opcode | uninit_wreg
                        | security_violation;

   // Source order follows the package indices
   assign src = {illegal_any, trap_conflict, config_mismatch,
                 watchdog_timeout, reset_instruction, master_clear_pin,
                 brown_out_event, power_on_event};

   rscs_source_merge #(
      .NSRC(RSCS_NSRC)
   ) u_merge (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .src(src),
      .any_q(sys_rst_q),
      .rise_q(src_rise)
   );

   assign master_system_reset = sys_rst_q;

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   logic wait_q;
   logic req;
   logic accept;
   logic wr_cause;
   logic rd_status;

   assign req = read | write;
   // A request is taken on the edge where waitrequest is already low
   assign accept = clk_en & req & ~wait_q;
   assign wr_cause = accept & write & (address == RSCS_ADDR_CAUSE);
   assign rd_status = accept & read & (address == RSCS_ADDR_STATUS);
   assign waitrequest = wait_q;

   // One wait cycle per access gives time to register the read data
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_q <= RSCS_WAIT_IDLE;
      end else if (clk_en) begin
         wait_q <= ~(req & wait_q);
      end
   end

   // ----------------------------------------------------------------
   // Reset cause register
   // ----------------------------------------------------------------
   logic [RSCS_REG_W-1:0] cause_q;
   logic [RSCS_REG_W-1:0] cause_d;
   logic [RSCS_REG_W-1:0] wr_val;

   // Byte lanes 0 and 1 carry the 16-bit register
   assign wr_val = {byteenable[1] ? writedata[15:8] : cause_q[15:8],
                    byteenable[0] ? writedata[7:0] : cause_q[7:0]};

   // Later assignments win, so hardware sets override the bus write
   always_comb begin
      cause_d = cause_q;
      if (wr_cause) begin
         cause_d = wr_val & RSCS_CAUSE_WMASK;
      end
      if (sys_rst_q) begin
         // Software watchdog enable returns to off; flags are kept
         cause_d[RSCS_BIT_SOFT_WDT] = 1'b0;
      end
      if (idle_entered) begin
         cause_d[RSCS_BIT_IDLE] = 1'b1;
      end
      if (sleep_entered) begin
         cause_d[RSCS_BIT_SLEEP] = 1'b1;
      end
      for (int i = 0; i < RSCS_NSRC; i++) begin
         if (src[i]) begin
            cause_d[RSCS_SRC_BIT[i]] = 1'b1;
         end
      end
      if (src[RSCS_SRC_POR]) begin
         cause_d = RSCS_CAUSE_POR_ONLY;
      end
   end

   // Survives system reset except the software watchdog enable; only the block reset restores it
   always_ff @(posedge clk) begin
      if (rst) begin
         cause_q <= RSCS_CAUSE_RESET;
      end else if (clk_en) begin
         cause_q <= cause_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   logic [RSCS_REG_W-1:0] status_q;
   logic [RSCS_REG_W-1:0] status_d;
   logic [RSCS_REG_W-1:0] mask_q;
   logic [RSCS_REG_W-1:0] mask_d;
   logic [RSCS_REG_W-1:0] ev_bits;

   // Map source edges onto the cause register layout
   always_comb begin
      ev_bits = '0;
      for (int i = 0; i < RSCS_NSRC; i++) begin
         ev_bits[RSCS_SRC_BIT[i]] = src_rise[i];
      end
   end

   // Read clears, but an event in the same cycle stays set
   assign status_d = ((rd_status ? '0 : status_q) | ev_bits)
                     & RSCS_EVENT_MASK;
   assign mask_d = (accept & write & (address == RSCS_ADDR_MASK))
                   ? (writedata[15:0] & RSCS_EVENT_MASK) : mask_q;

   // Status and mask registers
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= '0;
         mask_q <= '0;
      end else if (clk_en) begin
         status_q <= status_d;
         mask_q <= mask_d;
      end
   end

   // Level interrupt taken from next-state values to save a cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(status_d & mask_d);
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Loaded when the wait cycle ends; unmapped words read as zero
   // Status uses its next value so an event at this edge survives the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         readdata <= '0;
      end else if (clk_en && read && wait_q) begin
         unique case (address)
            RSCS_ADDR_CAUSE: readdata <= {16'h0000, cause_q};
            RSCS_ADDR_STATUS: readdata <= {16'h0000, status_d};
            RSCS_ADDR_MASK: readdata <= {16'h0000, mask_q};
            default: readdata <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Watchdog and regulator controls
   // ----------------------------------------------------------------
   // Fuse setting forces the watchdog on whatever software wrote
   always_ff @(posedge clk) begin
      if (rst) begin
         watchdog_run <= 1'b0;
         regulator_sleep_standby <= 1'b0;
      end else if (clk_en) begin
         watchdog_run <= fuse_watchdog_enable
                         | cause_d[RSCS_BIT_SOFT_WDT];
         regulator_sleep_standby <= cause_d[RSCS_BIT_REG_STBY];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_req_waiting;
      clk_en && (read || write) && waitrequest;
   endsequence

   sequence s_ack;
      !waitrequest;
   endsequence

   bus_handshake_a: assert property (s_req_waiting |=> s_ack)
      else $error("waitrequest did not drop after one wait cycle");

   master_system_reset_assert_a: assert property (
      clk_en && (|src) |=> master_system_reset)
      else $error("source active but master reset low");

   master_system_reset_release_a: assert property (
      clk_en && !(|src) |=> !master_system_reset)
      else $error("master reset not released one edge after sources");

   illegal_flag_a: assert property (
      clk_en && !power_on_event
      && (illegal_opcode || uninit_wreg || security_violation)
      |=> cause_q[RSCS_BIT_ILLEGAL])
      else $error("illegal condition flag not set");

   por_clear_a: assert property (
      clk_en && power_on_event |=> cause_q == RSCS_CAUSE_POR_ONLY)
      else $error("power-on did not leave only the power-on flag");

   trap_flag_a: assert property (
      clk_en && trap_conflict && !power_on_event
      |=> cause_q[RSCS_BIT_TRAP] ##1 (cause_q[RSCS_BIT_TRAP]
      || $past(wr_cause) || $past(power_on_event) || !$past(clk_en)))
      else $error("trap conflict flag not set or lost");

   cfg_flag_a: assert property (
      clk_en && config_mismatch && !power_on_event
      |=> cause_q[RSCS_BIT_CFG_MISM])
      else $error("configuration mismatch flag not set");

   idle_flag_a: assert property (
      clk_en && idle_entered && !power_on_event
      |=> cause_q[RSCS_BIT_IDLE])
      else $error("idle history flag not set");

   wdt_fuse_a: assert property (
      clk_en && fuse_watchdog_enable |=> watchdog_run)
      else $error("watchdog not running with fuse enable set");

   sw_write_a: assert property (
      wr_cause && byteenable[1:0] == 2'h3 && !(|src) && !sys_rst_q
      && !idle_entered && !sleep_entered
      |=> cause_q == (writedata[15:0] & RSCS_CAUSE_WMASK))
      else $error("software write not stored in cause register");

   write_no_reset_a: assert property (
      wr_cause && !(|src) |=> !master_system_reset)
      else $error("software write raised the master reset");

   set_wins_a: assert property (
      wr_cause && watchdog_timeout && !power_on_event
      |=> cause_q[RSCS_BIT_WATCHDOG])
      else $error("software write beat a hardware flag set");

   irq_level_a: assert property (
      clk_en |=> irq == |(status_q & mask_q))
      else $error("interrupt level disagrees with status and mask");

endmodule : rscs_top

// ### verification/reset_source_combiner_status_tb.sv
// Self-checking bench for the reset source combiner
module reset_source_combiner_status_tb
   import rscs_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, idle_entered = 1'b0, sleep_entered = 1'b0;
   logic fuse_watchdog_enable = 1'b0, read = 1'b0, write = 1'b0;
   logic clk_en = 1'b1;
   logic [1:0] address = 2'h0;
   logic [31:0] writedata = 32'h0, readdata;
   logic [3:0] byteenable = 4'hf;
   logic [9:0] cmd = 10'h0;
   logic waitrequest, master_system_reset, watchdog_run, irq;
   logic regulator_sleep_standby;
   logic pwr, brn, pin, ins, wdt, cfg, trp, opc, uwr, sec;
   logic [15:0] rd;
   int failures = 0, check_count = 0;
   // Flag bit set by each model command line
   int bit_of [10] = '{RSCS_BIT_POWER_ON, RSCS_BIT_BROWN_OUT, RSCS_BIT_PIN,
      RSCS_BIT_INSTR, RSCS_BIT_WATCHDOG, RSCS_BIT_CFG_MISM, RSCS_BIT_TRAP,
      RSCS_BIT_ILLEGAL, RSCS_BIT_ILLEGAL, RSCS_BIT_ILLEGAL};

   // Clock at 100 MHz
   initial begin
      forever #5 clk = ~clk;
   end

   rscs_source_model model (.clk(clk), .cmd(cmd), .power_on_event(pwr),
      .brown_out_event(brn), .master_clear_pin(pin), .reset_instruction(ins),
      .watchdog_timeout(wdt), .config_mismatch(cfg), .trap_conflict(trp),
      .illegal_opcode(opc), .uninit_wreg(uwr), .security_violation(sec));

   rscs_top uut (.clk(clk), .rst(rst), .clk_en(clk_en), .power_on_event(pwr),
      .brown_out_event(brn), .master_clear_pin(pin), .reset_instruction(ins),
      .watchdog_timeout(wdt), .config_mismatch(cfg), .trap_conflict(trp),
      .illegal_opcode(opc), .uninit_wreg(uwr), .security_violation(sec),
      .idle_entered(idle_entered), .sleep_entered(sleep_entered),
      .fuse_watchdog_enable(fuse_watchdog_enable), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .master_system_reset(master_system_reset),
      .watchdog_run(watchdog_run),
      .regulator_sleep_standby(regulator_sleep_standby), .irq(irq));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Verdict and end of run
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask : chk

   // One Avalon access; the request holds until waitrequest is seen low
   task automatic bus(input logic wr, input logic [1:0] a,
                      input logic [15:0] d);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      read <= ~wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata[15:0];
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50) begin
         $display("Error bus answer expected waitrequest low seen timeout");
         failures++;
      end
   endtask : bus

   // Raise one source, hold it, then drop it and watch the release
   task automatic fire(input int i);
      @(posedge clk);
      cmd <= 10'h001 << i;
      repeat (4) @(posedge clk);
      chk("reset out held", 16'h1, 16'(master_system_reset));
      cmd <= 10'h000;
      repeat (3) @(posedge clk);
      chk("reset out released", 16'h0, 16'(master_system_reset));
   endtask : fire

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Each source alone leaves its own flag; power-on leaves only bit 0
   task automatic sc_sources;
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, RSCS_ADDR_CAUSE, (i == 0) ? 16'hc3fe : 16'h0000);
         fire(i);
         bus(1'b0, RSCS_ADDR_CAUSE, 16'h0);
         chk("cause flag", 16'h1 << bit_of[i], rd);
      end
   endtask : sc_sources

   // Software sets every flag without a reset; reserved bits read zero
   task automatic sc_soft_write;
      bus(1'b1, RSCS_ADDR_CAUSE, 16'hffff);
      bus(1'b0, RSCS_ADDR_CAUSE, 16'h0);
      chk("cause all set", 16'hc3ff, rd);
      chk("no soft reset", 16'h0, 16'(master_system_reset));
      chk("standby out", 16'h1, 16'(regulator_sleep_standby));
      bus(1'b0, 2'h3, 16'h0);
      chk("unmapped read", 16'h0, rd);
   endtask : sc_soft_write

   // Idle and sleep history, then the watchdog enables
   task automatic sc_power;
      bus(1'b1, RSCS_ADDR_CAUSE, 16'h0000);
      // The run output changes on the same edge as the write; sample it one edge on
      @(posedge clk);
      chk("wdt off", 16'h0, 16'(watchdog_run));
      idle_entered <= 1'b1;
      @(posedge clk);
      idle_entered <= 1'b0;
      bus(1'b0, RSCS_ADDR_CAUSE, 16'h0);
      chk("idle flag", 16'h0004, rd);
      @(posedge clk);
      sleep_entered <= 1'b1;
      @(posedge clk);
      sleep_entered <= 1'b0;
      bus(1'b0, RSCS_ADDR_CAUSE, 16'h0);
      chk("sleep flag", 16'h000c, rd);
      bus(1'b1, RSCS_ADDR_CAUSE, 16'h0020);
      @(posedge clk);
      chk("wdt soft on", 16'h1, 16'(watchdog_run));
      bus(1'b1, RSCS_ADDR_CAUSE, 16'h0000);
      fuse_watchdog_enable <= 1'b1;
      repeat (2) @(posedge clk);
      chk("wdt fuse on", 16'h1, 16'(watchdog_run));
      fuse_watchdog_enable <= 1'b0;
   endtask : sc_power

   // Masked pin event stays quiet, watchdog event interrupts, read clears
   task automatic sc_irq;
      bus(1'b1, RSCS_ADDR_MASK, 16'h0010);
      bus(1'b0, RSCS_ADDR_STATUS, 16'h0);
      fire(2);
      chk("irq masked", 16'h0, 16'(irq));
      fire(4);
      chk("irq raised", 16'h1, 16'(irq));
      bus(1'b0, RSCS_ADDR_STATUS, 16'h0);
      chk("status", 16'h0090, rd);
      repeat (2) @(posedge clk);
      chk("irq cleared", 16'h0, 16'(irq));
   endtask : sc_irq

   // Clock enable low freezes the merged reset until it returns
   task automatic sc_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      cmd <= 10'h004;
      repeat (4) @(posedge clk);
      chk("frozen reset", 16'h0, 16'(master_system_reset));
      clk_en <= 1'b1;
      repeat (2) @(posedge clk);
      chk("thawed reset", 16'h1, 16'(master_system_reset));
      cmd <= 10'h000;
      repeat (3) @(posedge clk);
   endtask : sc_freeze

   // Low-lane cause write during a watchdog time-out; the level source
   // keeps re-setting its flag, the assertion watches the exact edge
   task automatic sc_set_wins;
      @(posedge clk);
      cmd <= 10'h010;
      byteenable <= 4'h1;
      repeat (2) @(posedge clk);
      bus(1'b1, RSCS_ADDR_CAUSE, 16'hff00);
      byteenable <= 4'hf;
      bus(1'b0, RSCS_ADDR_CAUSE, 16'h0);
      chk("set beats write", 16'h0010, rd);
      cmd <= 10'h000;
      repeat (3) @(posedge clk);
   endtask : sc_set_wins

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("reset out idle", 16'h0, 16'(master_system_reset));
      bus(1'b0, RSCS_ADDR_CAUSE, 16'h0);
      chk("cause reset value", RSCS_CAUSE_RESET, rd);
      sc_sources();
      sc_soft_write();
      sc_power();
      sc_irq();
      sc_freeze();
      sc_set_wins();
      test_done();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #200000;
      failures++;
      test_done();
   end
endmodule : reset_source_combiner_status_tb

// ### verification/rscs_source_model.sv
// Behavioural model of the reset sources that feed the combiner
module rscs_source_model (
   input wire logic clk,
   input wire logic [9:0] cmd,
   output logic power_on_event,
   output logic brown_out_event,
   output logic master_clear_pin,
   output logic reset_instruction,
   output logic watchdog_timeout,
   output logic config_mismatch,
   output logic trap_conflict,
   output logic illegal_opcode,
   output logic uninit_wreg,
   output logic security_violation
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Source levels
   // ------------------------------------------------------------
   // Levels launch on an edge like a synchronised monitor output;
   // the three illegal causes stay separate lines
   always_ff @(posedge clk) begin
      {security_violation, uninit_wreg, illegal_opcode, trap_conflict,
       config_mismatch, watchdog_timeout, reset_instruction,
       master_clear_pin, brown_out_event, power_on_event} <= cmd;
   end
endmodule : rscs_source_model
